// File: core/swd_counter.sv
/*
 * Time-out counter stepped by oscillator ticks.
 * Assumes ticks, restarts and selection arrive on the system clock.
 */
`timescale 1ns/1ps
module swd_counter
    import swd_pkg::*;
#(
    parameter int BASE = BASE_TICKS
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    swd_cnt_if.cnt    cif
);
    logic [CNT_W-1:0] cnt_reg;    // Ticks since last restart
    logic [CNT_W-1:0] limit;      // Current time-out in ticks
    logic             hit;        // Last tick of the period
    logic             exp_reg;    // Expiry pulse

    assign limit = swd_limit(cif.sel, CNT_W'(BASE));
    // Greater-or-equal so that a shorter selection still expires
    assign hit = cif.tick && cif.run && (cnt_reg >= limit - 1'b1);

    // ----------------------------------------
    // Count
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
        end else if (cif.restart || !cif.run || hit) begin
            cnt_reg <= '0;
        end else if (cif.tick) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // ----------------------------------------
    // Expiry pulse
    // ----------------------------------------
    // A restart in the same cycle as the last tick wins over expiry
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            exp_reg <= 1'b0;
        end else begin
            exp_reg <= hit && !cif.restart;
        end
    end

    assign cif.expire = exp_reg;
endmodule : swd_counter

// File: core/swd_pin_sync.sv
/*
 * Three-stage synchroniser with agreement filter for asynchronous pins.
 * Assumes inputs are levels that stay put for several system clocks.
 */
`timescale 1ns/1ps
module swd_pin_sync #(
    parameter int W = 2
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] s1_reg;    // Metastability catcher, read by s2 only
    logic [W-1:0] s2_reg;    // Second stage
    logic [W-1:0] s3_reg;    // Third stage
    logic [W-1:0] lvl_reg;   // Filtered level

    // ----------------------------------------
    // Shift chain
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // ----------------------------------------
    // Agreement filter
    // ----------------------------------------
    // A bit changes only when stages two and three agree
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lvl_reg <= '0;
        end else begin
            lvl_reg <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
        end
    end

    assign level_o = lvl_reg;
endmodule : swd_pin_sync

// File: core/swd_top.sv
/*
 * Supervision timer with timed change sequence: register port, mode
 * logic, fuse override, interrupt and reset request generation.
 * Assumes the core gives one-cycle restart and vector pulses on clk_i,
 * and that sys_rst_i is the power-on reset, not the reset it requests.
 */
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module swd_top
    import swd_pkg::*;
#(
    parameter int BASE = BASE_TICKS              // Ticks at code 0000, shorten in simulation
) (
    input  wire logic                        clk_i,
    input  wire logic                        sys_rst_i,
    input  wire logic                        osc_i,
    input  wire logic                        always_on_fuse_i,
    input  wire logic                        restart_i,
    input  wire logic                        irq_ack_i,
    input  wire logic [swd_pkg::ADDR_W-1:0]  reg_addr_i,
    input  wire logic [swd_pkg::DATA_W-1:0]  reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    output logic      [swd_pkg::DATA_W-1:0]  reg_rdata_o,
    output logic                             timeout_irq_o,
    output logic                             sys_reset_req_o
);
    import swd_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    swd_cnt_if         cif ();               // Link to the counter
    logic [1:0]        pins;                 // Filtered {fuse, oscillator}
    logic              osc_lvl;              // Filtered oscillator level
    logic              fuse_on;              // Fuse programmed
    logic              osc_prev_reg;         // Oscillator level last cycle
    logic              tick;                 // One oscillator cycle seen
    logic              irq_flag_reg;         // timeout_irq_flag
    logic              irq_en_reg;           // timeout_irq_enable_bit as written
    logic              rst_en_reg;           // reset_enable_bit as written
    logic [SEL_W-1:0]  sel_reg;              // timeout_select_field
    logic [2:0]        win_reg;              // Cycles left in change window
    logic              cause_reg;            // watchdog_reset_cause_flag
    logic              irq_en_eff;           // Enable after fuse override
    logic              rst_en_eff;           // Enable after fuse and flag override
    logic              chg_en;               // change_enable_bit as read
    swd_mode_t         mode;                 // Active mode
    logic              wr_ctrl;              // Write to control register
    logic              wr_cause;             // Write to cause register
    logic              open_win;             // Write that opens the window
    logic              cfg_write;            // Write consumed by the window
    logic              do_irq;               // Expiry sets the interrupt flag
    logic              do_rst;               // Expiry requests a reset
    logic [DATA_W-1:0] ctrl_val;             // Control register as read
    logic [DATA_W-1:0] cause_val;            // Cause register as read
    logic              rst_req_reg;          // Reset request pulse
    logic              irq_out_reg;          // Interrupt line
    logic [DATA_W-1:0] rdata_reg;            // Read data

    // ----------------------------------------
    // Pin synchronisation and tick
    // ----------------------------------------
    // Both pins are asynchronous to clk_i; one synchroniser serves both
    swd_pin_sync #(
        .W (2)
    ) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     ({always_on_fuse_i, osc_i}),
        .level_o   (pins)
    );

    assign osc_lvl = pins[0];
    assign fuse_on = pins[1];

    // Edge history of the filtered oscillator level
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            osc_prev_reg <= 1'b0;
        end else begin
            osc_prev_reg <= osc_lvl;
        end
    end

    // One tick per rising oscillator edge, needs clk_i well above 256 kHz
    assign tick = osc_lvl && !osc_prev_reg;

    // ----------------------------------------
    // Effective enables and mode
    // ----------------------------------------
    assign irq_en_eff = irq_en_reg && !fuse_on;
    assign rst_en_eff = rst_en_reg || cause_reg || fuse_on;
    assign mode       = swd_mode_t'({rst_en_eff, irq_en_eff});
    assign chg_en     = (win_reg != 3'h0);

    // ----------------------------------------
    // Counter hookup
    // ----------------------------------------
    // Commands are already on clk_i, ticks come through the synchroniser
    assign cif.tick    = tick;
    assign cif.restart = restart_i || rst_req_reg;
    assign cif.run     = (mode != SWD_STOPPED);
    assign cif.sel     = sel_reg;

    swd_counter #(
        .BASE (BASE)
    ) u_cnt (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .cif       (cif)
    );

    // ----------------------------------------
    // Expiry action per mode
    // ----------------------------------------
    // Combined mode resets only if the first interrupt is still pending
    always_comb begin
        do_irq = 1'b0;
        do_rst = 1'b0;
        if (cif.expire) begin
            case (mode)
                SWD_IRQ: begin
                    do_irq = 1'b1;
                end
                SWD_RST: begin
                    do_rst = 1'b1;
                end
                SWD_BOTH: begin
                    do_irq = !irq_flag_reg;
                    do_rst = irq_flag_reg;
                end
                default: begin
                    do_irq = 1'b0;
                    do_rst = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    assign wr_ctrl  = reg_wr_i && (reg_addr_i == ADDR_CTRL);
    assign wr_cause = reg_wr_i && (reg_addr_i == ADDR_CAUSE);

    // Opening needs change enable and reset enable in the same write
    assign open_win = wr_ctrl && reg_wdata_i[BIT_CHG_EN]
                      && reg_wdata_i[BIT_RST_EN];
    // The single write taken inside the window, with change enable low
    assign cfg_write = wr_ctrl && chg_en
                       && !reg_wdata_i[BIT_CHG_EN];

    // ----------------------------------------
    // Change window
    // ----------------------------------------
    // Counts down four cycles, closed early by the accepted write
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            win_reg <= 3'h0;
        end else if (open_win) begin
            win_reg <= CHG_WIN;
        end else if (cfg_write) begin
            win_reg <= 3'h0;
        end else if (chg_en) begin
            win_reg <= win_reg - 3'h1;
        end
    end

    // ----------------------------------------
    // Reset enable
    // ----------------------------------------
    // Outside the window a write may only set it, never clear it
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_en_reg <= RST_EN_RST;
        end else if (cfg_write) begin
            rst_en_reg <= reg_wdata_i[BIT_RST_EN];
        end else if (wr_ctrl) begin
            rst_en_reg <= rst_en_reg | reg_wdata_i[BIT_RST_EN];
        end
    end

    // ----------------------------------------
    // Time-out selection
    // ----------------------------------------
    // Changed only by the write accepted in the window
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_reg <= SEL_RESET;
        end else if (cfg_write) begin
            sel_reg <= {reg_wdata_i[BIT_SEL_HI],
                        reg_wdata_i[BIT_SEL_LO+2:BIT_SEL_LO]};
        end
    end

    // ----------------------------------------
    // Interrupt enable
    // ----------------------------------------
    // Free to write; vector in combined mode drops it to reset mode
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_en_reg <= 1'b0;
        end else if (wr_ctrl) begin
            irq_en_reg <= reg_wdata_i[BIT_IRQ_EN];
        end else if (irq_ack_i && irq_flag_reg && mode == SWD_BOTH) begin
            irq_en_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Interrupt flag
    // ----------------------------------------
    // Set wins over a write-one clear or the vector clear
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_flag_reg <= 1'b0;
        end else if (do_irq) begin
            irq_flag_reg <= 1'b1;
        end else if (irq_ack_i) begin
            irq_flag_reg <= 1'b0;
        end else if (wr_ctrl && reg_wdata_i[BIT_IRQ_FLAG]) begin
            irq_flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Reset cause flag
    // ----------------------------------------
    // Cleared only by power-on or a written zero; set wins
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cause_reg <= 1'b0;
        end else if (do_rst) begin
            cause_reg <= 1'b1;
        end else if (wr_cause && !reg_wdata_i[BIT_CAUSE]) begin
            cause_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Reset request
    // ----------------------------------------
    // One clock long; also restarts the counter for the next period
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_req_reg <= 1'b0;
        end else begin
            rst_req_reg <= do_rst;
        end
    end

    // ----------------------------------------
    // Interrupt line
    // ----------------------------------------
    // Level, registered on clk_i, so it rises only on a system clock edge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_out_reg <= 1'b0;
        end else begin
            irq_out_reg <= (irq_flag_reg || do_irq) && irq_en_eff;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        ctrl_val                            = RD_ZERO;
        ctrl_val[BIT_IRQ_FLAG]              = irq_flag_reg;
        ctrl_val[BIT_IRQ_EN]                = irq_en_eff;
        ctrl_val[BIT_SEL_HI]                = sel_reg[3];
        ctrl_val[BIT_CHG_EN]                = chg_en;
        ctrl_val[BIT_RST_EN]                = rst_en_eff;
        ctrl_val[BIT_SEL_LO+2:BIT_SEL_LO]   = sel_reg[2:0];
        cause_val                           = RD_ZERO;
        cause_val[BIT_CAUSE]                = cause_reg;
    end

    // Valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_reg <= RD_ZERO;
        end else if (reg_rd_i && reg_addr_i == ADDR_CTRL) begin
            rdata_reg <= ctrl_val;
        end else if (reg_rd_i && reg_addr_i == ADDR_CAUSE) begin
            rdata_reg <= cause_val;
        end else begin
            rdata_reg <= RD_ZERO;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata_o     = rdata_reg;
    assign timeout_irq_o   = irq_out_reg;
    assign sys_reset_req_o = rst_req_reg;

endmodule : swd_top

// File: dv/swd_core_model.sv
/* Core side model: free-running oscillator and an interrupt vector that acks.
   Assumes the bench enables servicing only where a scenario wants it. */
`timescale 1ns/1ps
module swd_core_model #(
    parameter int OSC_HALF_NS = 3906             // Half period of the 128 kHz oscillator
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic irq_i,
    input  wire logic svc_en_i,
    output logic      osc_o,
    output logic      irq_ack_o
);
    logic [1:0] hold_reg;                        // Holdoff so one interrupt gets one vector
    initial begin
        osc_o = 1'b0;
        forever #(OSC_HALF_NS) osc_o = ~osc_o;
    end
    // Vector entry: one-cycle pulse per serviced interrupt
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_ack_o <= 1'b0;
            hold_reg  <= 2'h0;
        end else begin
            irq_ack_o <= 1'b0;
            if (hold_reg != 2'h0) begin
                hold_reg <= hold_reg - 2'h1;
            end else if (svc_en_i && irq_i) begin
                irq_ack_o <= 1'b1;
                hold_reg  <= 2'h3;
            end
        end
    end
endmodule : swd_core_model

// File: dv/swd_top_asserts.sv
/* Port checker for swd_top: timed change window, reset pulse, cause flag, fuse.
   Assumes swd_pkg is compiled first; bound to every swd_top below. */
`timescale 1ns/1ps
module swd_top_asserts
    import swd_pkg::*;
#(
    parameter int BASE = BASE_TICKS              // Same as the design, period not checked here
) (
    input wire logic                       clk_i,
    input wire logic                       sys_rst_i,
    input wire logic                       osc_i,
    input wire logic                       always_on_fuse_i,
    input wire logic                       restart_i,
    input wire logic                       irq_ack_i,
    input wire logic [swd_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [swd_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic                       reg_wr_i,
    input wire logic                       reg_rd_i,
    input wire logic [swd_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic                       timeout_irq_o,
    input wire logic                       sys_reset_req_o
);
    logic rst_seen;                              // Reset requested, cause not yet cleared
    logic rd_ctrl;                               // Control register read strobe
    assign rd_ctrl = reg_rd_i && reg_addr_i == ADDR_CTRL;
    // ----------------------------------------
    // Helper: remembers a requested reset
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_seen <= 1'b0;
        end else if (sys_reset_req_o) begin
            rst_seen <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == ADDR_CAUSE && !reg_wdata_i[BIT_CAUSE]) begin
            rst_seen <= 1'b0;
        end
    end
    sequence s_open;
        reg_wr_i && reg_addr_i == ADDR_CTRL && reg_wdata_i[BIT_CHG_EN] && reg_wdata_i[BIT_RST_EN];
    endsequence
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_win_open: assert property (s_open ##1 !reg_wr_i ##1 rd_ctrl |=> reg_rdata_o[BIT_CHG_EN])
        else $error("change enable not seen inside window");
    chk_win_close: assert property (s_open ##1 ((!reg_wr_i) throughout (##[6:20] rd_ctrl))
        |=> !reg_rdata_o[BIT_CHG_EN]) else $error("change enable still set after window");
    chk_rst_pulse: assert property (sys_reset_req_o |=> !sys_reset_req_o [*8])
        else $error("reset request longer than one cycle");
    chk_restart_quiet: assert property (restart_i |-> ##2 !sys_reset_req_o [*8])
        else $error("reset request right after restart");
    chk_cause_set: assert property (rst_seen && reg_rd_i && reg_addr_i == ADDR_CAUSE
        |=> reg_rdata_o[BIT_CAUSE]) else $error("cause flag missing after reset");
    chk_cause_holds: assert property (rst_seen && rd_ctrl |=> reg_rdata_o[BIT_RST_EN])
        else $error("reset enable clear while cause flag set");
    chk_fuse_mode: assert property (always_on_fuse_i [*8] ##0 rd_ctrl
        |=> reg_rdata_o[BIT_RST_EN] && !reg_rdata_o[BIT_IRQ_EN]) else $error("fuse did not force reset mode");
    chk_ack_clears: assert property (irq_ack_i |-> ##2 !timeout_irq_o)
        else $error("interrupt stays after vector");
endmodule : swd_top_asserts
bind swd_top swd_top_asserts #(.BASE(BASE)) i_swd_top_asserts (.clk_i, .sys_rst_i, .osc_i, .always_on_fuse_i,
    .restart_i, .irq_ack_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .timeout_irq_o,
    .sys_reset_req_o);

// File: dv/swd_top_test.sv
/* Self-checking bench for swd_top with BASE shortened to 4 ticks.
   Assumes swd_pkg, the checker and the core model are compiled first. */
`timescale 1ns/1ps
module swd_top_test;
    import swd_pkg::*;
    logic              clk_i = 0, sys_rst_i = 1, always_on_fuse_i = 0, restart_i = 0;
    logic              reg_wr_i = 0, reg_rd_i = 0, svc_en = 0;
    logic              osc_i, irq_ack_i, timeout_irq_o, sys_reset_req_o;
    logic [ADDR_W-1:0] reg_addr_i = 0;
    logic [DATA_W-1:0] reg_wdata_i = 0, reg_rdata_o;
    int                fails = 0, n_checks = 0, n_rst = 0, k, n0;
    swd_top #(.BASE(4)) i_swd_top (.clk_i, .sys_rst_i, .osc_i, .always_on_fuse_i, .restart_i, .irq_ack_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .timeout_irq_o, .sys_reset_req_o);
    swd_core_model i_swd_core_model (.clk_i, .sys_rst_i, .irq_i(timeout_irq_o), .svc_en_i(svc_en),
        .osc_o(osc_i), .irq_ack_o(irq_ack_i));
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (sys_reset_req_o) n_rst++;
    end
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 0;
        @(negedge clk_i);
        chk($sformatf("reg%0h", a), reg_rdata_o, e);
    endtask : rd
    task automatic kick;
        @(posedge clk_i);
        restart_i <= 1;
        @(posedge clk_i);
        restart_i <= 0;
    endtask : kick
    // Bounded wait for interrupt (s=1) or reset request (s=0)
    task automatic wt(input bit s, input int n);
        k = 0;
        while (!(s ? timeout_irq_o : sys_reset_req_o) && k < n) begin
            @(negedge clk_i);
            k++;
        end
        chk(s ? "irq_wait" : "rst_wait", 8'(k < n), 8'h01);
    endtask : wt
    task automatic t_seq;
        rd(ADDR_CTRL, 8'h00);
        wr(4'h5, 8'hff);
        rd(4'h5, 8'h00);
        wr(ADDR_CTRL, 8'h08);
        wr(ADDR_CTRL, 8'h18);
        rd(ADDR_CTRL, 8'h18);
        repeat (5) @(posedge clk_i);
        rd(ADDR_CTRL, 8'h08);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CTRL, 8'h08);
        wr(ADDR_CTRL, 8'h18);
        wr(ADDR_CTRL, 8'h09);
        rd(ADDR_CTRL, 8'h09);
        kick;
        wt(0, 900);
        chk("period", 8'(k >= 546 && k <= 712), 8'h01);
        rd(ADDR_CAUSE, 8'h08);
        wt(0, 900);
        @(negedge clk_i);
        n0 = n_rst;
        repeat (4) begin
            repeat (300) @(posedge clk_i);
            kick;
        end
        chk("kept_alive", 8'(n_rst - n0), 8'h00);
        wr(ADDR_CTRL, 8'h18);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CTRL, 8'h08);
        wr(ADDR_CAUSE, 8'h00);
        wr(ADDR_CTRL, 8'h18);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CTRL, 8'h00);
        $display("t_seq done");
    endtask : t_seq
    task automatic t_irq;
        n0 = n_rst;
        wr(ADDR_CTRL, 8'h40);
        kick;
        wt(1, 500);
        rd(ADDR_CTRL, 8'hc0);
        wr(ADDR_CTRL, 8'hc0);
        rd(ADDR_CTRL, 8'h40);
        wt(1, 500);
        svc_en <= 1;
        repeat (8) @(negedge clk_i);
        svc_en <= 0;
        chk("irq_low", 8'(timeout_irq_o), 8'h00);
        chk("no_reset", 8'(n_rst - n0), 8'h00);
        wr(ADDR_CTRL, 8'h80);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_both;
        wr(ADDR_CTRL, 8'h48);
        kick;
        wt(1, 500);
        svc_en <= 1;
        repeat (8) @(negedge clk_i);
        svc_en <= 0;
        rd(ADDR_CTRL, 8'h08);
        wr(ADDR_CTRL, 8'h48);
        kick;
        wt(1, 500);
        wt(0, 500);
        wr(ADDR_CAUSE, 8'h00);
        wr(ADDR_CTRL, 8'h80);
        wr(ADDR_CTRL, 8'h18);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CTRL, 8'h00);
        $display("t_both done");
    endtask : t_both
    task automatic t_fuse;
        wr(ADDR_CTRL, 8'h40);
        @(posedge clk_i);
        always_on_fuse_i <= 1;
        repeat (8) @(posedge clk_i);
        rd(ADDR_CTRL, 8'h08);
        kick;
        wt(0, 500);
        chk("irq_off", 8'(timeout_irq_o), 8'h00);
        $display("t_fuse done");
    endtask : t_fuse
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // Tests need about 4500 cycles; cut off at 40000
    initial begin
        #4000000;
        fails++;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 0;
        t_seq;
        t_irq;
        t_both;
        t_fuse;
        end_of_test;
    end
endmodule : swd_top_test

// File: pkg/swd_cnt_if.sv
/*
 * Carrier between the control logic and the time-out counter.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface swd_cnt_if;
    import swd_pkg::*;
    logic             tick;     // One-cycle pulse per oscillator cycle
    logic             restart;  // One-cycle pulse, count back to zero
    logic             run;      // Level, counter may advance
    logic [SEL_W-1:0] sel;      // Time-out selection
    logic             expire;   // One-cycle pulse at time-out

    modport ctl (output tick, output restart, output run, output sel, input expire);
    modport cnt (input tick, input restart, input run, input sel, output expire);
endinterface : swd_cnt_if

// File: pkg/swd_pkg.sv
/*
 * Shared constants and types of the supervision timer: register map,
 * field positions, reset values, window length and mode encoding.
 * Assumes an 8-bit register port and a single system clock.
 */
package swd_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int DATA_W = 8;                       // Register data width
    localparam int ADDR_W = 4;                       // Register address width
    localparam int SEL_W  = 4;                       // Time-out select width
    localparam int CNT_W  = 21;                      // Holds up to 2^20 ticks

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL  = 4'h0; // supervision_control_register
    localparam logic [ADDR_W-1:0] ADDR_CAUSE = 4'h1; // reset_cause_register

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_IRQ_FLAG = 7;                 // timeout_irq_flag
    localparam int BIT_IRQ_EN   = 6;                 // timeout_irq_enable_bit
    localparam int BIT_SEL_HI   = 5;                 // timeout_select_field bit 3
    localparam int BIT_CHG_EN   = 4;                 // change_enable_bit
    localparam int BIT_RST_EN   = 3;                 // reset_enable_bit
    localparam int BIT_SEL_LO   = 0;                 // timeout_select_field bits 2..0
    localparam int BIT_CAUSE    = 3;                 // watchdog_reset_cause_flag

    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [SEL_W-1:0]  SEL_RESET  = 4'h0;  // Shortest period after reset
    localparam logic [SEL_W-1:0]  SEL_MAX    = 4'h9;  // Last defined code
    localparam logic              RST_EN_RST = 1'b0;  // Reset enable after power-on
    localparam logic [2:0]        CHG_WIN    = 3'h4;  // Change window, clock cycles
    localparam logic [DATA_W-1:0] RD_ZERO    = 8'h00; // Idle read data
    localparam int                BASE_TICKS = 2048;  // Ticks at code 0000

    // ----------------------------------------
    // Operating modes: {reset enable, irq enable}
    // ----------------------------------------
    typedef enum logic [1:0] {
        SWD_STOPPED = 2'b00,
        SWD_IRQ     = 2'b01,
        SWD_RST     = 2'b10,
        SWD_BOTH    = 2'b11
    } swd_mode_t;

    // Time-out in oscillator ticks; reserved codes use the longest period
    function automatic logic [CNT_W-1:0] swd_limit(input logic [SEL_W-1:0] sel,
                                                    input logic [CNT_W-1:0] base);
        logic [SEL_W-1:0] s;
        s = (sel > SEL_MAX) ? SEL_MAX : sel;
        swd_limit = base << s;
    endfunction : swd_limit

endpackage : swd_pkg
